// ---- src/sfc_pkg.sv ----
package sfc_pkg;

    // ************************************************************
    // Frame geometry
    // ************************************************************
    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned GROUP_BITS  = 8;
    localparam int unsigned CNT_W       = 16;
    localparam logic [15:0] RESP_RESET  = 16'h0000;
    localparam logic        FAULT_RESET = 1'b0;

    typedef enum logic [1:0] {
        SFC_IDLE  = 2'b00,
        SFC_SHIFT = 2'b01,
        SFC_MUTED = 2'b10
    } sfc_state_t;

endpackage

// ---- src/sfc_slave.sv ----
// Summary of operation
// (RQ1) Four-wire full-duplex serial slave at host rate.
// (RQ2) Select falling edge starts access; data only while low.
// (RQ3) Sample serial input on shift clock falling edge.
// (RQ4) Update serial output on shift clock rising edge.
// (RQ5) Host ends each access raising chip select.
// (RQ6) Accept only 16 plus multiple-of-8 bits.
// (RQ7) Bad bit count sets framing fault flag.
// (RQ8) Deselected: ignore clock and input, output released.
// (RQ9) Select falling edge loads response into shifter.
// (RQ10) Output first shows fault flag ORed with input.
// (RQ11) Sleep: output stays released, no transfer.
// (RQ12) Both directions shift most significant bit first.
// (RQ13) Valid frame end copies shifter out; invalid ignored.
// (RQ14) Host keeps shift clock low around select edges.
// (RQ15) Sleep input gates response load and drive.
`timescale 1ns/1ps

module sfc_slave
    import sfc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        sclk,
    input  wire logic        chip_select_n,
    input  wire logic        sdi,
    output logic             sdo,
    output logic             sdo_oe,
    input  wire logic        sleep_mode,
    input  wire logic [15:0] resp_data,
    output logic [15:0]      frame_data,
    output logic             frame_valid,
    output logic             framing_fault_flag
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0] sclk_meta;
    logic [1:0] csn_meta;
    logic [1:0] sdi_meta;
    logic       sclk_q;
    logic       csn_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_meta <= 2'b00;
            csn_meta  <= 2'b11;
            sdi_meta  <= 2'b00;
            sclk_q    <= 1'b0;
            csn_q     <= 1'b1;
        end else begin
            sclk_meta <= {sclk_meta[0], sclk}; // [RQ1]
            csn_meta  <= {csn_meta[0], chip_select_n};
            sdi_meta  <= {sdi_meta[0], sdi};
            sclk_q    <= sclk_meta[1];
            csn_q     <= csn_meta[1];
        end
    end

    logic sclk_s;
    logic csn_s;
    logic sdi_s;
    logic sclk_fall;
    logic sclk_rise;
    logic csn_fall;
    logic csn_rise;

    assign sclk_s    = sclk_meta[1];
    assign csn_s     = csn_meta[1];
    assign sdi_s     = sdi_meta[1];
    assign sclk_fall = sclk_q & ~sclk_s;
    assign sclk_rise = ~sclk_q & sclk_s;
    assign csn_fall  = csn_q & ~csn_s;
    assign csn_rise  = ~csn_q & csn_s;

    function automatic logic count_ok(input logic [CNT_W-1:0] n);
        count_ok = (n >= CNT_W'(FRAME_BITS))
                 && ((n % CNT_W'(GROUP_BITS)) == '0);
    endfunction

    // ************************************************************
    // Frame engine
    // ************************************************************
    sfc_state_t       state;
    sfc_state_t       next_state;
    logic [15:0]      shreg;
    logic [15:0]      next_shreg;
    logic [CNT_W-1:0] bit_cnt;
    logic [CNT_W-1:0] next_bit_cnt;
    logic             next_sdo;
    logic             next_sdo_oe;
    logic [15:0]      next_frame_data;
    logic             next_frame_valid;
    logic             next_fault;

    always_comb begin
        next_state       = state;
        next_shreg       = shreg;
        next_bit_cnt     = bit_cnt;
        next_sdo         = sdo;
        next_sdo_oe      = sdo_oe;
        next_frame_data  = frame_data;
        next_frame_valid = 1'b0;
        next_fault       = framing_fault_flag;
        case (state)
            SFC_IDLE: begin
                next_sdo_oe = 1'b0; // [RQ8]
                if (csn_fall) begin // [RQ2]
                    if (sleep_mode) begin
                        next_state = SFC_MUTED; // [RQ11] [RQ15]
                    end else begin
                        next_state   = SFC_SHIFT;
                        next_shreg   = resp_data; // [RQ9] [RQ15]
                        next_bit_cnt = '0;
                        next_sdo     = framing_fault_flag | sdi_s; // [RQ10]
                        next_sdo_oe  = 1'b1;
                    end
                end
            end
            SFC_SHIFT: begin
                if (csn_rise) begin // [RQ5]
                    next_state  = SFC_IDLE;
                    next_sdo_oe = 1'b0; // [RQ8]
                    if (count_ok(bit_cnt)) begin // [RQ6]
                        next_frame_data  = shreg; // [RQ13]
                        next_frame_valid = 1'b1;
                        next_fault       = 1'b0;
                    end else begin
                        next_fault = 1'b1; // [RQ7]
                    end
                end else begin
                    if (sclk_fall) begin
                        next_shreg   = {shreg[14:0], sdi_s}; // [RQ3] [RQ12]
                        if (bit_cnt != '1) begin
                            next_bit_cnt = bit_cnt + 1'b1;
                        end
                    end
                    if (sclk_rise) begin
                        next_sdo = shreg[15]; // [RQ4] [RQ12]
                    end
                end
            end
            SFC_MUTED: begin
                next_sdo_oe = 1'b0; // [RQ11]
                if (csn_rise) begin
                    next_state = SFC_IDLE;
                end
            end
            default: begin
                next_state  = SFC_IDLE;
                next_sdo_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state              <= SFC_IDLE;
            shreg              <= RESP_RESET;
            bit_cnt            <= '0;
            sdo                <= 1'b0;
            sdo_oe             <= 1'b0;
            frame_data         <= RESP_RESET;
            frame_valid        <= 1'b0;
            framing_fault_flag <= FAULT_RESET;
        end else begin
            state              <= next_state;
            shreg              <= next_shreg;
            bit_cnt            <= next_bit_cnt;
            sdo                <= next_sdo;
            sdo_oe             <= next_sdo_oe;
            frame_data         <= next_frame_data;
            frame_valid        <= next_frame_valid;
            framing_fault_flag <= next_fault;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_select_start;
        state == SFC_IDLE && csn_fall && !sleep_mode;
    endsequence

    a_drive_on_select: assert property ( // [RQ10]
        @(posedge clk) disable iff (!arst_n)
        s_select_start |=> sdo_oe && sdo == $past(framing_fault_flag | sdi_s))
        else $error("output not driven with fault OR input");

    a_sleep_no_drive: assert property ( // [RQ11]
        @(posedge clk) disable iff (!arst_n)
        state == SFC_IDLE && csn_fall && sleep_mode |=> !sdo_oe ##1 !sdo_oe)
        else $error("output driven in sleep");

    a_load_response: assert property ( // [RQ9]
        @(posedge clk) disable iff (!arst_n)
        s_select_start |=> shreg == $past(resp_data))
        else $error("response not loaded");

    // A select line seen high on two samples means the access has ended.
    a_release_idle: assert property ( // [RQ8]
        @(posedge clk) disable iff (!arst_n)
        csn_q && csn_s |-> !sdo_oe)
        else $error("output driven while deselected");

    a_sample_fall: assert property ( // [RQ3]
        @(posedge clk) disable iff (!arst_n)
        state == SFC_SHIFT && !csn_rise && sclk_fall
        |=> shreg[0] == $past(sdi_s) && shreg[15:1] == $past(shreg[14:0]))
        else $error("input not shifted on falling edge");

    a_update_rise: assert property ( // [RQ4]
        @(posedge clk) disable iff (!arst_n)
        state == SFC_SHIFT && !csn_rise && sclk_rise
        |=> sdo == $past(shreg[15]))
        else $error("output not updated on rising edge");

    a_accept_frame: assert property ( // [RQ6] [RQ13]
        @(posedge clk) disable iff (!arst_n)
        state == SFC_SHIFT && csn_rise && count_ok(bit_cnt)
        |=> frame_valid && frame_data == $past(shreg) && !framing_fault_flag)
        else $error("valid frame not accepted");

    a_fault_set: assert property ( // [RQ7]
        @(posedge clk) disable iff (!arst_n)
        state == SFC_SHIFT && csn_rise && !count_ok(bit_cnt)
        |=> framing_fault_flag && !frame_valid)
        else $error("bad count did not set fault");

    a_count_fall: assert property ( // [RQ3]
        @(posedge clk) disable iff (!arst_n)
        state == SFC_SHIFT && !csn_rise && !sclk_fall |=> $stable(bit_cnt))
        else $error("count moved without clock edge");

endmodule

// ---- verif/sfc_host.sv ----
`timescale 1ns/1ps

module sfc_host (
    input  wire logic clk,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    output logic      sclk,
    output logic      chip_select_n,
    output logic      sdi
);
    localparam int HALF = 15;

    // A released line shows the inverse of its last level.
    logic so_line;
    assign so_line = sdo_oe ? sdo : ~sdo;

    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        sdi = 1'b0;
    end

    task automatic hw(inout logic oe);
        repeat (HALF) begin
            @(posedge clk);
            oe |= sdo_oe;
        end
    endtask

    task automatic xfer(input int n, input logic [31:0] d, input logic pre,
                        output logic [31:0] q, output logic first,
                        output logic oe);
        q = '0;
        oe = 1'b0;
        @(posedge clk);
        sdi <= pre;
        @(posedge clk);
        chip_select_n <= 1'b0;
        hw(oe);
        first = so_line;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            sclk <= 1'b1;
            sdi  <= d[i];
            hw(oe);
            q = {q[30:0], so_line};
            @(posedge clk);
            sclk <= 1'b0;
            hw(oe);
        end
        @(posedge clk);
        chip_select_n <= 1'b1;
        // The slave must ignore the input while deselected.
        @(posedge clk);
        sdi <= ~sdi;
    endtask

    task automatic wiggle(input int n, output logic oe);
        oe = 1'b0;
        repeat (2 * n) begin
            @(posedge clk);
            sclk <= ~sclk;
            sdi  <= ~sdi;
            hw(oe);
        end
    endtask
endmodule

// ---- verif/sfc_slave_test.sv ----
`timescale 1ns/1ps

module sfc_slave_test;
    logic        clk;
    logic        arst_n;
    logic        sleep_mode;
    logic [15:0] resp_data;
    logic        sclk;
    logic        chip_select_n;
    logic        sdi;
    logic        sdo;
    logic        sdo_oe;
    logic [15:0] frame_data;
    logic        frame_valid;
    logic        framing_fault_flag;
    logic [31:0] q;
    logic        first;
    logic        oe;
    int          miscompares;
    int          samples_checked;
    int          vc;
    int          v;

    sfc_slave sfc_slave_inst (.clk(clk), .arst_n(arst_n), .sclk(sclk),
        .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .sleep_mode(sleep_mode), .resp_data(resp_data),
        .frame_data(frame_data), .frame_valid(frame_valid),
        .framing_fault_flag(framing_fault_flag));
    sfc_host sfc_host_inst (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe),
        .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) if (frame_valid === 1'b1) vc <= vc + 1;

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic frame(input int n, input logic [31:0] d, input logic p);
        v = vc;
        sfc_host_inst.xfer(n, d, p, q, first, oe);
        repeat (8) @(posedge clk);
    endtask

    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_good;
        resp_data <= 16'hA5C3;
        frame(16, 32'h0000_3C5A, 1'b0);
        chk(oe, 1'b1);
        chk(first, 1'b0);
        chk(q[15:0], 16'hA5C3);
        chk(frame_data, 16'h3C5A);
        chk(vc - v, 1);
        chk(framing_fault_flag, 1'b0);
        chk(sdo_oe, 1'b0);
        $display("test good frame done");
    endtask

    task automatic t_bad;
        resp_data <= 16'h1234;
        frame(20, 32'h000F_FFFF, 1'b1);
        chk(first, 1'b1);
        chk(framing_fault_flag, 1'b1);
        chk(vc - v, 0);
        chk(frame_data, 16'h3C5A);
        frame(24, 32'h00AB_CDEF, 1'b0);
        chk(first, 1'b1);
        chk(q[23:8], 16'h1234);
        chk(frame_data, 16'hCDEF);
        chk(vc - v, 1);
        chk(framing_fault_flag, 1'b0);
        $display("test bit count done");
    endtask

    task automatic t_sleep;
        frame(12, 32'h0000_0ABC, 1'b0);
        chk(framing_fault_flag, 1'b1);
        sleep_mode <= 1'b1;
        frame(16, 32'h0000_FFFF, 1'b1);
        sleep_mode <= 1'b0;
        chk(framing_fault_flag, 1'b1);
        chk(oe, 1'b0);
        chk(vc - v, 0);
        chk(frame_data, 16'hCDEF);
        v = vc;
        sfc_host_inst.wiggle(10, oe);
        chk(oe, 1'b0);
        chk(vc - v, 0);
        $display("test sleep and idle done");
    endtask

    task automatic t_reset;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk(framing_fault_flag, 1'b0);
        chk(frame_data, 16'h0000);
        chk(sdo_oe, 1'b0);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        resp_data <= 16'h6E2D;
        frame(16, 32'h0000_1357, 1'b0);
        chk(first, 1'b0);
        chk(q[15:0], 16'h6E2D);
        chk(frame_data, 16'h1357);
        chk(vc - v, 1);
        $display("test mid-run reset done");
    endtask

    initial begin
        #200000;
        miscompares++;
        stop_test();
    end

    initial begin
        arst_n = 1'b0;
        sleep_mode = 1'b0;
        resp_data = 16'h0000;
        vc = 0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_good();
        t_bad();
        t_sleep();
        t_reset();
        stop_test();
    end
endmodule
